// ---- hw/efm_pkg.sv ----
/*
   shared constants and carrier types for the enclosure fault monitor.
   assumes a 32-bit apb slave with 12 address bits decoded.
*/
`default_nettype none

package efm_pkg;

   // ***************************************************************
   // sizes
   // ***************************************************************
   localparam int NUM_IN      = 4;
   localparam int SLOTS_A     = 20;
   localparam int SLOTS_B     = 21;
   localparam int NUM_SLOTS   = SLOTS_A + SLOTS_B;
   localparam int NUM_ENTRIES = 16;
   localparam int SLOT_W      = 6;
   localparam int ENT_W       = 4;
   localparam int ADDR_W      = 12;
   localparam int SYNC_STAGES = 2;

   // input order inside every four-bit field
   localparam int IN_PWR  = 0;
   localparam int IN_FAN  = 1;
   localparam int IN_TEMP = 2;
   localparam int IN_UPS  = 3;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [ADDR_W-1:0] ADDR_CTRL       = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_STATUS     = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_TOGGLE     = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_ENTRY_BASE = 12'h040;
   localparam logic [ADDR_W-1:0] ADDR_ENTRY_LAST = 12'h07c;

   // control word fields
   localparam int CTRL_MON_EN_BIT   = 0;
   localparam int CTRL_IN_EN_LSB    = 4;
   localparam int CTRL_IN_POL_LSB   = 8;
   localparam int CTRL_SLOT_POL_BIT = 12;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // status word fields
   localparam int STAT_FAIL_LSB  = 0;
   localparam int STAT_ATTN_BIT  = 4;
   localparam int STAT_RAW_LSB   = 8;
   localparam int STAT_ANY_BIT   = 16;

   // drive entry word fields
   localparam int ENT_SLOT_LSB   = 0;
   localparam int ENT_FAILED_BIT = 8;
   localparam int ENT_TEST_BIT   = 9;

   // slot value meaning unassigned
   localparam logic [SLOT_W-1:0] SLOT_NONE = 6'h00;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic              slot_pol;
      logic [NUM_IN-1:0] in_pol;
      logic [NUM_IN-1:0] in_en;
      logic              mon_en;
   } efm_ctrl_t;

   typedef struct packed {
      logic              test;
      logic              failed;
      logic [SLOT_W-1:0] slot;
   } efm_entry_t;

endpackage

`default_nettype wire

// ---- hw/efm_sync.sv ----
/*
   two-stage level synchroniser, one lane per bit.
   assumes each lane is a slow level from outside the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module efm_sync
#(
   parameter int W = 4
)
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   // first stage is read only by the second stage
   always_comb
   begin
      next_meta = d;
      next_q    = meta;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= next_meta;
         q    <= next_q;
      end
   end

endmodule

`default_nettype wire

// ---- hw/efm_monitor.sv ----
/*
   enclosure fault monitor: four failure inputs, 41 slot outputs,
   summary output, attention indicator and alert pulse, apb registers.
   assumes the enclosure circuit drives steady levels on fault_in and
   a single-master apb at pclk.
*/
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module efm_monitor
(
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [efm_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [efm_pkg::NUM_IN-1:0]    fault_in,
   output logic      [efm_pkg::SLOTS_A-1:0]   slot_a_out,
   output logic      [efm_pkg::SLOTS_B-1:0]   slot_b_out,
   output logic                               any_slot_out,
   output logic                               attention_indicator,
   output logic                               alert_event
);

   // ***************************************************************
   // decode helpers
   // ***************************************************************

   // one-hot of a slot number; zero and out-of-range give nothing
   function automatic logic [efm_pkg::NUM_SLOTS-1:0] slot_onehot
   (
      input logic [efm_pkg::SLOT_W-1:0] slot
   );
      logic [efm_pkg::NUM_SLOTS-1:0] v;
      v = '0;
      for (int n = 1; n <= efm_pkg::NUM_SLOTS; n++)
      begin
         if (slot == n[efm_pkg::SLOT_W-1:0])
         begin
            v[n-1] = 1'b1;
         end
      end
      return v;
   endfunction

   // entry index of an entry-window address
   function automatic logic [efm_pkg::ENT_W-1:0] entry_index
   (
      input logic [efm_pkg::ADDR_W-1:0] addr
   );
      logic [efm_pkg::ADDR_W-1:0] off;
      off = addr - efm_pkg::ADDR_ENTRY_BASE;
      return off[efm_pkg::ENT_W+1:2];
   endfunction

   // ***************************************************************
   // input synchronisers
   // ***************************************************************
   logic [efm_pkg::NUM_IN-1:0] fault_sync;

   // plain level sampling, no analog sensing here
   efm_sync
   #(
      .W (efm_pkg::NUM_IN)
   )
   u_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (fault_in),
      .q       (fault_sync)
   );

   // ***************************************************************
   // apb access decode
   // ***************************************************************
   logic wr_acc;
   logic rd_acc;
   logic hit_ctrl;
   logic hit_status;
   logic hit_toggle;
   logic hit_entry;
   logic hit_any;

   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;

   always_comb
   begin
      hit_ctrl   = (paddr == efm_pkg::ADDR_CTRL);
      hit_status = (paddr == efm_pkg::ADDR_STATUS);
      hit_toggle = (paddr == efm_pkg::ADDR_TOGGLE);
      hit_entry  = (paddr >= efm_pkg::ADDR_ENTRY_BASE)
                && (paddr <= efm_pkg::ADDR_ENTRY_LAST)
                && (paddr[1:0] == 2'h0);
      hit_any    = hit_ctrl | hit_status | hit_toggle | hit_entry;
      wr_acc     = psel & penable & pwrite;
      rd_acc     = psel & penable & ~pwrite;
      pslverr    = psel & penable & ~hit_any;
   end

   // ***************************************************************
   // control and drive entry registers
   // ***************************************************************
   efm_pkg::efm_ctrl_t  ctrl;
   efm_pkg::efm_ctrl_t  next_ctrl;
   efm_pkg::efm_entry_t entry      [efm_pkg::NUM_ENTRIES];
   efm_pkg::efm_entry_t next_entry [efm_pkg::NUM_ENTRIES];
   logic [efm_pkg::ENT_W-1:0] wr_idx;
   logic [efm_pkg::ENT_W-1:0] tog_idx;
   localparam logic [31:0]    CTRL_INIT = efm_pkg::CTRL_RESET;

   always_comb
   begin
      next_ctrl = ctrl;
      wr_idx    = entry_index(paddr);
      tog_idx   = pwdata[efm_pkg::ENT_W-1:0];
      if (wr_acc && hit_ctrl)
      begin
         next_ctrl.mon_en   = pwdata[efm_pkg::CTRL_MON_EN_BIT];
         next_ctrl.in_en    = pwdata[efm_pkg::CTRL_IN_EN_LSB +:
                                     efm_pkg::NUM_IN];
         next_ctrl.in_pol   = pwdata[efm_pkg::CTRL_IN_POL_LSB +:
                                     efm_pkg::NUM_IN];
         next_ctrl.slot_pol = pwdata[efm_pkg::CTRL_SLOT_POL_BIT];
      end
      for (int i = 0; i < efm_pkg::NUM_ENTRIES; i++)
      begin
         next_entry[i] = entry[i];
         if (wr_acc && hit_entry && (wr_idx == i[efm_pkg::ENT_W-1:0]))
         begin
            next_entry[i].slot   = pwdata[efm_pkg::ENT_SLOT_LSB +:
                                          efm_pkg::SLOT_W];
            next_entry[i].failed = pwdata[efm_pkg::ENT_FAILED_BIT];
            next_entry[i].test   = pwdata[efm_pkg::ENT_TEST_BIT];
         end
         if (wr_acc && hit_toggle && (tog_idx == i[efm_pkg::ENT_W-1:0]))
         begin
            next_entry[i].test = ~entry[i].test;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl.mon_en <= CTRL_INIT[efm_pkg::CTRL_MON_EN_BIT];
         ctrl.in_en <= CTRL_INIT[efm_pkg::CTRL_IN_EN_LSB +: efm_pkg::NUM_IN];
         ctrl.in_pol <= CTRL_INIT[efm_pkg::CTRL_IN_POL_LSB +: efm_pkg::NUM_IN];
         ctrl.slot_pol <= CTRL_INIT[efm_pkg::CTRL_SLOT_POL_BIT];
         for (int i = 0; i < efm_pkg::NUM_ENTRIES; i++)
         begin
            entry[i] <= '0;
         end
      end
      else
      begin
         ctrl <= next_ctrl;
         for (int i = 0; i < efm_pkg::NUM_ENTRIES; i++)
         begin
            entry[i] <= next_entry[i];
         end
      end
   end

   // ***************************************************************
   // failure inputs, status and alert
   // ***************************************************************
   logic [efm_pkg::NUM_IN-1:0] active;
   logic [efm_pkg::NUM_IN-1:0] fail;
   logic [efm_pkg::NUM_IN-1:0] next_fail;
   logic                       next_attn;
   logic                       next_alert;

   always_comb
   begin
      // polarity bit high means the line is active high
      active     = ~(fault_sync ^ ctrl.in_pol);
      next_fail  = active & ctrl.in_en;
      next_attn  = ctrl.mon_en & (|next_fail);
      // alert on a fresh failure or on monitoring switching on over one
      next_alert = (ctrl.mon_en & (|(next_fail & ~fail)))
                 | (next_attn & ~attention_indicator);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fail                <= '0;
         attention_indicator <= 1'b0;
         alert_event         <= 1'b0;
      end
      else
      begin
         fail                <= next_fail;
         attention_indicator <= next_attn;
         alert_event         <= next_alert;
      end
   end

   // ***************************************************************
   // slot outputs
   // ***************************************************************
   logic [efm_pkg::NUM_SLOTS-1:0] ent_hits [efm_pkg::NUM_ENTRIES];
   logic [efm_pkg::NUM_SLOTS-1:0] slot_lit;
   logic [efm_pkg::NUM_SLOTS-1:0] next_slots;
   logic                          next_any;

   // each entry lights its slot when failed, inverted by its test bit
   genvar g;
   generate
      for (g = 0; g < efm_pkg::NUM_ENTRIES; g++)
      begin : g_ent
         assign ent_hits[g] = (entry[g].failed ^ entry[g].test)
                            ? slot_onehot(entry[g].slot)
                            : '0;
      end
   endgenerate

   always_comb
   begin
      slot_lit = '0;
      for (int i = 0; i < efm_pkg::NUM_ENTRIES; i++)
      begin
         slot_lit = slot_lit | ent_hits[i];
      end
      // drive the pins in the chosen polarity; high means active high
      next_slots = ctrl.slot_pol ? slot_lit : ~slot_lit;
      next_any   = ctrl.slot_pol ? (|slot_lit) : ~(|slot_lit);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // reset shows inactive-high pins because slot_pol resets to 0
         slot_a_out   <= '1;
         slot_b_out   <= '1;
         any_slot_out <= 1'b1;
      end
      else
      begin
         slot_a_out   <= next_slots[efm_pkg::SLOTS_A-1:0];
         slot_b_out   <= next_slots[efm_pkg::NUM_SLOTS-1:
                                    efm_pkg::SLOTS_A];
         any_slot_out <= next_any;
      end
   end

   // ***************************************************************
   // read data
   // ***************************************************************
   logic [31:0] next_rdata;
   logic [31:0] stat_word;
   logic [31:0] ctrl_word;
   logic [31:0] ent_word;

   always_comb
   begin
      ctrl_word = '0;
      ctrl_word[efm_pkg::CTRL_MON_EN_BIT]                   = ctrl.mon_en;
      ctrl_word[efm_pkg::CTRL_IN_EN_LSB +: efm_pkg::NUM_IN]  = ctrl.in_en;
      ctrl_word[efm_pkg::CTRL_IN_POL_LSB +: efm_pkg::NUM_IN] = ctrl.in_pol;
      ctrl_word[efm_pkg::CTRL_SLOT_POL_BIT]                 = ctrl.slot_pol;
      stat_word = '0;
      stat_word[efm_pkg::STAT_FAIL_LSB +: efm_pkg::NUM_IN] = fail;
      stat_word[efm_pkg::STAT_ATTN_BIT] = attention_indicator;
      stat_word[efm_pkg::STAT_RAW_LSB +: efm_pkg::NUM_IN]  = fault_sync;
      stat_word[efm_pkg::STAT_ANY_BIT]  = |slot_lit;
      ent_word = '0;
      ent_word[efm_pkg::ENT_SLOT_LSB +: efm_pkg::SLOT_W] =
         entry[wr_idx].slot;
      ent_word[efm_pkg::ENT_FAILED_BIT] = entry[wr_idx].failed;
      ent_word[efm_pkg::ENT_TEST_BIT]   = entry[wr_idx].test;
      next_rdata = '0;
      // read data is registered at the setup cycle so it is ready
      // in the access cycle without a wait state
      if (psel && !penable && !pwrite)
      begin
         if (hit_ctrl)
         begin
            next_rdata = ctrl_word;
         end
         else if (hit_status)
         begin
            next_rdata = stat_word;
         end
         else if (hit_entry)
         begin
            next_rdata = ent_word;
         end
      end
      else if (rd_acc)
      begin
         next_rdata = prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= '0;
      end
      else
      begin
         prdata <= next_rdata;
      end
   end

endmodule

`default_nettype wire

// ---- bench/efm_encl_model.sv ----
/*
   enclosure sensing circuit: merges fans, supplies and sensors into
   the four fault lines, wired for the polarity it is told.
   assumes its pol input matches the monitor's input polarity word.
*/
`timescale 1ns/1ps
`default_nettype none

module efm_encl_model
(
   input  wire logic [6:0] src,
   input  wire logic [3:0] pol,
   output logic      [3:0] fault_in
);
   // ********************
   // merge and drive
   // ********************
   // src: [1:0] supplies, [3:2] fans, [5:4] sensors, [6] ups mains loss
   logic [3:0] cnd;

   always_comb
   begin
      cnd      = {src[6], |src[5:4], |src[3:2], |src[1:0]};
      fault_in = ~(cnd ^ pol);
   end
endmodule

`default_nettype wire

// ---- bench/efm_monitor_assertions.sv ----
/*
   checker for efm_monitor: slot summary, attention, alert, bus replies.
   assumes it is bound into efm_monitor and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module efm_monitor_assertions
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  fault_in,
   input wire logic [19:0] slot_a_out,
   input wire logic [20:0] slot_b_out,
   input wire logic        any_slot_out,
   input wire logic        attention_indicator,
   input wire logic        alert_event
);
   // ********************
   // control shadow, built from observed writes
   // ********************
   efm_pkg::efm_ctrl_t ctl, next_ctl;
   logic               wr_q, wr_q2, next_wr, spol, act, mapped;

   always_comb
   begin
      next_wr  = psel && penable && pwrite;
      next_ctl = ctl;
      if (next_wr && paddr == 12'h000)
         next_ctl = '{pwdata[12], pwdata[11:8], pwdata[7:4], pwdata[0]};
      act      = |(ctl.in_en & ~(fault_in ^ ctl.in_pol));
      mapped   = paddr[1:0] == 2'h0 && (paddr <= 12'h008
                 || (paddr >= 12'h040 && paddr <= 12'h07c));
   end

   // slot pins lag the write edge by one, so the shadow lags too
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ctl   <= '0;
         wr_q  <= 1'b0;
         wr_q2 <= 1'b0;
         spol  <= 1'b0;
      end
      else
      begin
         ctl   <= next_ctl;
         wr_q  <= next_wr;
         wr_q2 <= wr_q;
         spol  <= ctl.slot_pol;
      end

   // ********************
   // properties
   // ********************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // synchroniser plus register needs three edges; sampled before each edge, four is the minimum
   sequence s_hot;
      (act && ctl.mon_en) [*4];
   endsequence
   sequence s_cold;
      (!act || !ctl.mon_en) [*4];
   endsequence

   chk_slot_sum: assert property (
      any_slot_out == (spol ? |{slot_b_out, slot_a_out}
                            : &{slot_b_out, slot_a_out}))
      else $error("summary pin disagrees with slot pins");
   chk_slot_hold: assert property (
      !wr_q2 |-> $stable({slot_b_out, slot_a_out}))
      else $error("slot pins moved without a write");
   chk_attn_set: assert property (
      s_hot |-> attention_indicator)
      else $error("attention missing for enabled active input");
   chk_attn_clear: assert property (
      s_cold |-> !attention_indicator)
      else $error("attention without enabled active input");
   chk_alert_attn: assert property (
      alert_event |-> attention_indicator)
      else $error("alert without attention");
   chk_attn_rise: assert property (
      $rose(attention_indicator) |-> alert_event)
      else $error("attention rose without alert");
   chk_rd_idle: assert property (
      !psel && !$past(psel) |-> prdata == 32'h0)
      else $error("read data outside a transfer");
   chk_err_resp: assert property (
      psel && penable |-> pslverr == !mapped)
      else $error("error reply wrong for address");
endmodule

bind efm_monitor efm_monitor_assertions efm_monitor_assertions_i
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
   .slot_a_out(slot_a_out), .slot_b_out(slot_b_out),
   .any_slot_out(any_slot_out), .alert_event(alert_event),
   .attention_indicator(attention_indicator)
);

`default_nettype wire

// ---- bench/tb.sv ----
/*
   self-checking bench for efm_monitor beside the enclosure model.
   assumes efm_monitor, efm_encl_model and the checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        any_slot_out, attention_indicator, alert_event;
   logic        at, pat;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, w;
   logic [3:0]  fault_in, pol, cnd, fl, pfl;
   logic [6:0]  src;
   logic [19:0] slot_a_out;
   logic [20:0] slot_b_out;
   logic [32:0] exp_q[$];
   logic [5:0]  slot_tab[6] = '{6'h01, 6'h14, 6'h15, 6'h29, 6'h00, 6'h2a};
   int          err_count, check_count, cyc, alert_n, alert_mark;

   efm_monitor efm_monitor_i
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
      .slot_a_out(slot_a_out), .slot_b_out(slot_b_out),
      .any_slot_out(any_slot_out), .alert_event(alert_event),
      .attention_indicator(attention_indicator)
   );
   efm_encl_model efm_encl_model_i
   (
      .src(src), .pol(pol), .fault_in(fault_in)
   );

   initial pclk = 1'b0;
   always #25 pclk = ~pclk;

   // ********************
   // checking and closing
   // ********************
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cmp_bus(input logic [32:0] e, input logic [32:0] a);
      check_count++;
      if (a !== e)
      begin
         err_count++;
         $display("mismatch at %0t: reply %h want %h", $time, a, e);
      end
   endtask

   // pins settle after the edge, so they are looked at on the low phase
   task automatic cmp_pins(input logic [41:0] e);
      @(negedge pclk);
      check_count++;
      if ({any_slot_out, slot_b_out, slot_a_out} !== e)
      begin
         err_count++;
         $display("mismatch at %0t: slot pins want %h", $time, e);
      end
      @(posedge pclk);
   endtask

   // attention level and the alert pulses counted since the mark
   task automatic cmp_attn(input logic e_attn, input int e_alert);
      @(negedge pclk);
      check_count++;
      if (attention_indicator !== e_attn || alert_n - alert_mark != e_alert)
      begin
         err_count++;
         $display("mismatch at %0t: attention want %b alerts want %0d",
                  $time, e_attn, e_alert);
      end
      @(posedge pclk);
   endtask

   always @(posedge pclk)
      if (alert_event === 1'b1)
         alert_n++;

   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
         cmp_bus(exp_q.pop_front(), {pslverr, prdata});

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         err_count++;
         stop_test();
      end
   end

   // ********************
   // bus master: one transfer, expected reply noted first
   // ********************
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      exp_q.push_back(e);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // ********************
   // scenarios
   // ********************
   initial
   begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr  = 12'h000;
      pwdata = 32'h0;
      src    = 7'h00;
      pol    = 4'h0;
      pfl    = 4'h0;
      pat    = 1'b0;
      void'($urandom(74));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      cmp_pins('1);
      bus(1'b0, 12'h000, 32'h0, 33'h0);
      for (int k = 0; k < 16; k++)
      begin
         w = $urandom;
         alert_mark = alert_n;
         src <= w[22:16];
         pol <= w[11:8];
         bus(1'b1, 12'h000, w & 32'h0000_0ff1, 33'h0);
         repeat (4) @(posedge pclk);
         cnd = {w[22], |w[21:20], |w[19:18], |w[17:16]};
         fl  = cnd & w[7:4];
         bus(1'b0, 12'h004, 32'h0, {21'h0, ~(cnd ^ w[11:8]), 3'h0,
             w[0] & |fl, fl});
         at = w[0] & |fl;
         cmp_attn(at, int'(at & (|(fl & ~pfl) | ~pat)));
         pfl = fl;
         pat = at;
      end
      pol <= 4'h0;
      src <= 7'h00;
      bus(1'b1, 12'h000, 32'h1, 33'h0);
      for (int i = 0; i < 6; i++)
         bus(1'b1, 12'h040 + 12'(4 * i), {23'h0, 1'b1, 2'h0, slot_tab[i]},
             33'h0);
      cmp_pins({1'b0, ~41'h100_0018_0001});
      bus(1'b0, 12'h044, 32'h0, 33'h114);
      bus(1'b1, 12'h008, 32'h1, 33'h0);
      cmp_pins({1'b0, ~41'h100_0010_0001});
      bus(1'b0, 12'h044, 32'h0, 33'h314);
      bus(1'b0, 12'h008, 32'h0, 33'h0);
      bus(1'b0, 12'h004, 32'h0, 33'h1_0f00);
      bus(1'b1, 12'h000, 32'h1001, 33'h0);
      cmp_pins({1'b1, 41'h100_0010_0001});
      bus(1'b0, 12'h00c, 32'h0, 33'h1_0000_0000);
      bus(1'b1, 12'h080, 32'hffff_ffff, 33'h1_0000_0000);
      bus(1'b0, 12'h042, 32'h0, 33'h1_0000_0000);
      bus(1'b0, 12'h000, 32'h0, 33'h1001);
      if (exp_q.size() != 0)
         err_count++;
      stop_test();
   end
endmodule

`default_nettype wire
